// ==== hw/apc_cal.sv ====
`timescale 1ns/10ps
`include "apc_consts.svh"
module apc_cal
	import apc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	apc_cal_if.cal   cal_bus
);

	function automatic apc_calpwr_t calibrate(apc_pwr_t p, apc_cal_t g, apc_cal_t o);
		logic signed [51:0] prod;
		logic signed [51:0] sum;
		prod = 52'(p) * 52'(g);
		sum  = 52'(p) + (prod >>> `APC_GAIN_FRAC) + 52'(o);
		return sum[31:0];
	endfunction

	// Results are held until the next sample so the accumulator sees stable data
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 6; i++) begin
				cal_bus.pwr_out[i] <= '0;
			end
		end else if (cal_bus.tick) begin
			for (int i = 0; i < 6; i++) begin
				cal_bus.pwr_out[i] <= calibrate(cal_bus.pwr_in[i], cal_bus.gain[i], cal_bus.offs[i]);
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cal_bus.valid <= 1'b0;
		end else begin
			cal_bus.valid <= cal_bus.tick;
		end
	end

endmodule

// ==== hw/apc_cal_if.sv ====
`timescale 1ns/10ps
interface apc_cal_if;
	import apc_pkg::*;
	apc_pwr_t    pwr_in  [6];
	apc_cal_t    gain    [6];
	apc_cal_t    offs    [6];
	logic        tick;
	apc_calpwr_t pwr_out [6];
	logic        valid;
	modport top (output pwr_in, output gain, output offs, output tick, input pwr_out, input valid);
	modport cal (input pwr_in, input gain, input offs, input tick, output pwr_out, output valid);
endinterface

// ==== hw/apc_consts.svh ====
`ifndef APC_CONSTS_SVH
`define APC_CONSTS_SVH

`define APC_ADDR_COMP_MODE  8'h00
`define APC_ADDR_ACC_MODE   8'h01
`define APC_ADDR_VOLT_LEVEL 8'h02
`define APC_ADDR_GAIN_BASE 8'h03
`define APC_ADDR_OFFS_BASE 8'h09
`define APC_ADDR_THR_LO    8'h0F
`define APC_ADDR_THR_HI    8'h10
`define APC_ADDR_STATUS    8'h11
`define APC_ADDR_MASK      8'h12
`define APC_ADDR_SIGN      8'h13
`define APC_ADDR_SETTLE    8'h14

`define APC_BIT_FREQ_SEL   14
`define APC_BIT_REV_SEL    6
`define APC_REV_LSB        6
`define APC_GAIN_FRAC      23

`define APC_RST_CAL        24'h000000
`define APC_RST_WORD       32'h00000000

`define APC_CLK_MHZ        20
`define APC_SAMPLE_US      125
`define APC_SAMPLE_CYC     (`APC_SAMPLE_US * `APC_CLK_MHZ)
`define APC_SETTLE_MS      875
`define APC_SETTLE_CYC     (`APC_SETTLE_MS * 1000 * `APC_CLK_MHZ)

`endif

// ==== hw/apc_pkg.sv ====
package apc_pkg;
	typedef logic signed [27:0] apc_pwr_t;
	typedef logic signed [23:0] apc_cal_t;
	typedef logic signed [31:0] apc_calpwr_t;
	typedef logic signed [51:0] apc_acc_t;
	typedef logic [2:0]         apc_phase_t;
endpackage

// ==== hw/apc_top.sv ====
`timescale 1ns/10ps
`include "apc_consts.svh"
module apc_top
	import apc_pkg::*;
#(
	parameter int unsigned SETTLE_CYC = `APC_SETTLE_CYC
)
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic [27:0] total_pwr_a,
	input  wire logic [27:0] total_pwr_b,
	input  wire logic [27:0] total_pwr_c,
	input  wire logic [27:0] fund_pwr_a,
	input  wire logic [27:0] fund_pwr_b,
	input  wire logic [27:0] fund_pwr_c,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             reg_rvalid,
	output logic             line_freq_select,
	output logic             sample_tick,
	output logic             interrupt_out_n
);

	apc_cal_if cal_bus ();

	apc_cal u_cal (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.cal_bus (cal_bus)
	);

	logic [31:0] compensation_mode_reg;
	logic [31:0] accumulation_mode_reg;
	apc_cal_t    nominal_voltage_level_reg;
	apc_cal_t    gain_reg [6];
	apc_cal_t    offs_reg [6];
	logic [23:0] thr_lo_reg;
	logic [23:0] thr_hi_reg;
	apc_phase_t  rev_status_reg;
	apc_phase_t  rev_mask_reg;
	apc_phase_t  phase_sign_reg;
	logic [11:0] tick_cnt_reg;
	logic [31:0] settle_cnt_reg;
	logic        fund_settled_reg;
	apc_acc_t    acc_reg [3];
	apc_phase_t  rev_event;
	apc_phase_t  new_sign;
	apc_acc_t    acc_next [3];
	logic        rev_sel;
	apc_acc_t    threshold;
	logic        init_wr;

	// Register words: 24-bit signed value, sign extended to 28, top four zero
	function automatic logic [31:0] pack24(apc_cal_t v);
		return {4'h0, {4{v[23]}}, v};
	endfunction

	function automatic logic wr_hit(logic [7:0] a);
		return reg_wr && (reg_addr == a);
	endfunction

	assign rev_sel   = accumulation_mode_reg[`APC_BIT_REV_SEL];
	assign threshold = 52'($signed({thr_hi_reg, thr_lo_reg}));
	assign init_wr   = wr_hit(`APC_ADDR_VOLT_LEVEL) || wr_hit(`APC_ADDR_COMP_MODE);
	assign line_freq_select = compensation_mode_reg[`APC_BIT_FREQ_SEL];

	assign cal_bus.pwr_in[0] = total_pwr_a;
	assign cal_bus.pwr_in[1] = total_pwr_b;
	assign cal_bus.pwr_in[2] = total_pwr_c;
	assign cal_bus.pwr_in[3] = fund_pwr_a;
	assign cal_bus.pwr_in[4] = fund_pwr_b;
	assign cal_bus.pwr_in[5] = fund_pwr_c;
	assign cal_bus.tick      = sample_tick;
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			cal_bus.gain[i] = gain_reg[i];
			cal_bus.offs[i] = offs_reg[i];
		end
	end

	// 8 kHz sample rate derived from the system clock
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_reg <= '0;
			sample_tick  <= 1'b0;
		end else if (tick_cnt_reg == 12'(`APC_SAMPLE_CYC - 1)) begin
			tick_cnt_reg <= '0;
			sample_tick  <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 12'h001;
			sample_tick  <= 1'b0;
		end
	end

	// Configuration and calibration registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			compensation_mode_reg     <= `APC_RST_WORD;
			accumulation_mode_reg     <= `APC_RST_WORD;
			nominal_voltage_level_reg <= `APC_RST_CAL;
			thr_lo_reg                <= 24'h000000;
			thr_hi_reg                <= 24'h000000;
			rev_mask_reg              <= 3'h0;
			for (int i = 0; i < 6; i++) begin
				gain_reg[i] <= `APC_RST_CAL;
				offs_reg[i] <= `APC_RST_CAL;
			end
		end else if (reg_wr) begin
			if (reg_addr == `APC_ADDR_COMP_MODE) begin
				compensation_mode_reg <= reg_wdata;
			end
			if (reg_addr == `APC_ADDR_ACC_MODE) begin
				accumulation_mode_reg <= reg_wdata;
			end
			if (reg_addr == `APC_ADDR_VOLT_LEVEL) begin
				nominal_voltage_level_reg <= reg_wdata[23:0];
			end
			if (reg_addr == `APC_ADDR_THR_LO) begin
				thr_lo_reg <= reg_wdata[23:0];
			end
			if (reg_addr == `APC_ADDR_THR_HI) begin
				thr_hi_reg <= reg_wdata[23:0];
			end
			if (reg_addr == `APC_ADDR_MASK) begin
				rev_mask_reg <= reg_wdata[8:6];
			end
			for (int i = 0; i < 6; i++) begin
				if (reg_addr == `APC_ADDR_GAIN_BASE + 8'(i)) begin
					gain_reg[i] <= reg_wdata[23:0];
				end
				if (reg_addr == `APC_ADDR_OFFS_BASE + 8'(i)) begin
					offs_reg[i] <= reg_wdata[23:0];
				end
			end
		end
	end

	// Settling timer restarts whenever the fundamental algorithm is reinitialised
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			settle_cnt_reg   <= '0;
			fund_settled_reg <= 1'b0;
		end else if (init_wr) begin
			settle_cnt_reg   <= '0;
			fund_settled_reg <= 1'b0;
		end else if (settle_cnt_reg >= SETTLE_CYC - 1) begin
			fund_settled_reg <= 1'b1;
		end else begin
			settle_cnt_reg <= settle_cnt_reg + 32'h00000001;
		end
	end

	// First-stage energy: add, compare with threshold, remove one quantum
	always_comb begin
		apc_acc_t p;
		p = '0;
		for (int i = 0; i < 3; i++) begin
			p = 52'(rev_sel ? cal_bus.pwr_out[i + 3] : cal_bus.pwr_out[i]);
			acc_next[i]  = acc_reg[i] + p;
			new_sign[i]  = phase_sign_reg[i];
			rev_event[i] = 1'b0;
			if (cal_bus.valid) begin
				if (acc_next[i] >= threshold) begin
					acc_next[i] = acc_next[i] - threshold;
					new_sign[i] = 1'b0;
					rev_event[i] = phase_sign_reg[i];
				end else if (acc_next[i] <= -threshold) begin
					acc_next[i] = acc_next[i] + threshold;
					new_sign[i] = 1'b1;
					rev_event[i] = !phase_sign_reg[i];
				end
			end else begin
				acc_next[i] = acc_reg[i];
			end
		end
	end

	// Switching the monitored source restarts the quanta from zero
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 3; i++) begin
				acc_reg[i] <= '0;
			end
		end else if (wr_hit(`APC_ADDR_ACC_MODE) && (reg_wdata[`APC_BIT_REV_SEL] != rev_sel)) begin
			for (int i = 0; i < 3; i++) begin
				acc_reg[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				acc_reg[i] <= acc_next[i];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase_sign_reg <= 3'h0;
		end else begin
			phase_sign_reg <= new_sign;
		end
	end

	// New events win over a simultaneous clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rev_status_reg <= 3'h0;
		end else if (wr_hit(`APC_ADDR_STATUS)) begin
			rev_status_reg <= (rev_status_reg & ~reg_wdata[8:6]) | rev_event;
		end else begin
			rev_status_reg <= rev_status_reg | rev_event;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			interrupt_out_n <= 1'b1;
		end else begin
			interrupt_out_n <= ~|(rev_status_reg & rev_mask_reg);
		end
	end

	// Read port; reads have no side effects so status survives until cleared
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata  <= `APC_RST_WORD;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= `APC_RST_WORD;
				case (reg_addr)
					`APC_ADDR_COMP_MODE:  reg_rdata <= compensation_mode_reg;
					`APC_ADDR_ACC_MODE:   reg_rdata <= accumulation_mode_reg;
					`APC_ADDR_VOLT_LEVEL: reg_rdata <= pack24(nominal_voltage_level_reg);
					`APC_ADDR_THR_LO:   reg_rdata <= {8'h00, thr_lo_reg};
					`APC_ADDR_THR_HI:   reg_rdata <= {8'h00, thr_hi_reg};
					`APC_ADDR_STATUS:   reg_rdata <= {23'h000000, rev_status_reg, 6'h00};
					`APC_ADDR_MASK:     reg_rdata <= {23'h000000, rev_mask_reg, 6'h00};
					`APC_ADDR_SIGN:     reg_rdata <= {29'h00000000, phase_sign_reg};
					`APC_ADDR_SETTLE:   reg_rdata <= {31'h00000000, fund_settled_reg};
					default: begin
						for (int i = 0; i < 6; i++) begin
							if (reg_addr == `APC_ADDR_GAIN_BASE + 8'(i)) begin
								reg_rdata <= pack24(gain_reg[i]);
							end
							if (reg_addr == `APC_ADDR_OFFS_BASE + 8'(i)) begin
								reg_rdata <= pack24(offs_reg[i]);
							end
						end
					end
				endcase
			end
		end
	end

endmodule

// ==== tb/apc_checker.sv ====
`timescale 1ns/10ps
`include "apc_consts.svh"
module apc_checker
	import apc_pkg::*;
#(
	parameter int unsigned SETTLE_CYC = 50
)
(
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        reg_rvalid,
	input wire logic        line_freq_select,
	input wire logic        sample_tick,
	input wire logic        interrupt_out_n
);
	logic [11:0] gap_reg;
	logic        seen_reg;

	// First tick only arms the spacing check
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gap_reg <= 12'h000;
		end else begin
			gap_reg <= sample_tick ? 12'h000 : gap_reg + 12'h001;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			seen_reg <= 1'b0;
		end else begin
			seen_reg <= seen_reg | sample_tick;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_tick; seen_reg |-> gap_reg < 12'h9C4 && (!sample_tick || gap_reg == 12'h9C3); endproperty
	a_tick: assert property (p_tick) else $error("tick spacing wrong");
	property p_rvalid; reg_rvalid == $past(reg_rd); endproperty
	a_rvalid: assert property (p_rvalid) else $error("read valid misplaced");
	property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	// Only the 24-bit signed registers carry the sign-extended word
	property p_ext;
		reg_rvalid && $past(reg_addr) >= `APC_ADDR_VOLT_LEVEL && $past(reg_addr) < `APC_ADDR_THR_LO
			|-> reg_rdata[31:24] == {4'h0, {4{reg_rdata[23]}}};
	endproperty
	a_ext: assert property (p_ext) else $error("read word not sign extended");
	property p_thr_pad;
		reg_rvalid && ($past(reg_addr) == `APC_ADDR_THR_LO || $past(reg_addr) == `APC_ADDR_THR_HI)
			|-> reg_rdata[31:24] == 8'h00;
	endproperty
	a_thr_pad: assert property (p_thr_pad) else $error("threshold word not padded");
	property p_freq;
		reg_wr && reg_addr == `APC_ADDR_COMP_MODE |=> line_freq_select == $past(reg_wdata[`APC_BIT_FREQ_SEL]);
	endproperty
	a_freq: assert property (p_freq) else $error("frequency select not loaded");
	property p_freq_keep; !(reg_wr && reg_addr == `APC_ADDR_COMP_MODE) |=> $stable(line_freq_select); endproperty
	a_freq_keep: assert property (p_freq_keep) else $error("frequency select moved");
	property p_fall;
		$fell(interrupt_out_n) |-> $past(sample_tick, 2) || $past(sample_tick, 3) || $past(sample_tick, 4)
			|| $past(reg_wr) || $past(reg_wr, 2);
	endproperty
	a_fall: assert property (p_fall) else $error("interrupt without cause");
	property p_rise; $rose(interrupt_out_n) |-> $past(reg_wr) || $past(reg_wr, 2); endproperty
	a_rise: assert property (p_rise) else $error("interrupt released without write");
	property p_clear;
		reg_wr && reg_addr == `APC_ADDR_STATUS && reg_wdata[8:6] == 3'b111 && !sample_tick && !$past(sample_tick)
			&& !$past(sample_tick, 2) |-> ##[1:3] interrupt_out_n;
	endproperty
	a_clear: assert property (p_clear) else $error("status clear kept interrupt");
endmodule

bind apc_top apc_checker #(.SETTLE_CYC(SETTLE_CYC)) u_chk (
	.clk_sys         (clk_sys),
	.rst_n           (rst_n),
	.reg_addr        (reg_addr),
	.reg_wdata       (reg_wdata),
	.reg_wr          (reg_wr),
	.reg_rd          (reg_rd),
	.reg_rdata       (reg_rdata),
	.reg_rvalid      (reg_rvalid),
	.line_freq_select(line_freq_select),
	.sample_tick     (sample_tick),
	.interrupt_out_n (interrupt_out_n)
);

// ==== tb/apc_host.sv ====
`timescale 1ns/10ps
module apc_host (
	input  wire logic        clk_sys,
	output logic      [7:0]  reg_addr,
	output logic      [31:0] reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	input  wire logic [31:0] reg_rdata,
	input  wire logic        reg_rvalid
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 32'h00000000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Released lines invert, so stale values cannot pass for a decode
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = (reg_rvalid === 1'b1) ? reg_rdata : 32'hXXXXXXXX;
	endtask
endmodule

// ==== tb/apc_top_bench.sv ====
`timescale 1ns/10ps
`include "apc_consts.svh"
module apc_top_bench;
	import apc_pkg::*;
	typedef struct {int ph; int src; int offs; logic [23:0] cal; int p;} apc_row_t;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic [27:0] tp [3] = '{default: 28'h0000000};
	logic [27:0] fp [3] = '{default: 28'h0000000};
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic        reg_wr, reg_rd, reg_rvalid, line_freq_select, sample_tick, irq_n;
	int          bad_count = 0;
	int          comparisons = 0;
	int          cycles = 0;
	apc_row_t    rows [5] = '{'{0, 0, 0, 24'hC00000, -400}, '{1, 1, 0, 24'h400000, -400},
		'{2, 0, 1, 24'h0000C8, -400}, '{0, 1, 1, 24'hFFFF38, -400}, '{2, 1, 0, 24'h000000, -1000}};

	apc_top #(.SETTLE_CYC(50)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .total_pwr_a(tp[0]), .total_pwr_b(tp[1]),
		.total_pwr_c(tp[2]), .fund_pwr_a(fp[0]), .fund_pwr_b(fp[1]), .fund_pwr_c(fp[2]), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.line_freq_select(line_freq_select), .sample_tick(sample_tick), .interrupt_out_n(irq_n));
	apc_host host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

	always #25 clk_sys = ~clk_sys;
	// Longest path is about 45000 cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			bad_count++;
			give_verdict();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		host.rd_reg(a, v);
		chk(v, exp);
	endtask
	task automatic rst();
		@(posedge clk_sys);
		rst_n <= 1'b0;
		tp <= '{default: 28'h0000000};
		fp <= '{default: 28'h0000000};
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		host.wr_reg(`APC_ADDR_THR_LO, 32'h000003E8);
	endtask
	task automatic give_verdict();
		$display("Counts: %0d compared, %0d failed", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Ticks until the running sum reaches minus threshold
	function automatic int ticks(apc_row_t r);
		longint c = r.p;
		c = r.offs ? c + longint'($signed(r.cal)) : c + ((longint'(r.p) * longint'($signed(r.cal))) >>> 23);
		c = (c < 0) ? -c : c;
		return int'((1000 + c - 1) / c);
	endfunction

	initial begin
		int n;
		rst();
		rdchk(`APC_ADDR_GAIN_BASE, 32'h00000000);
		rdchk(`APC_ADDR_OFFS_BASE + 8'h05, 32'h00000000);
		chk(32'(line_freq_select), 32'h00000000);
		host.wr_reg(`APC_ADDR_COMP_MODE, 32'h00004000);
		@(negedge clk_sys);
		chk(32'(line_freq_select), 32'h00000001);
		host.wr_reg(`APC_ADDR_VOLT_LEVEL, 32'h000F0000);
		rdchk(`APC_ADDR_VOLT_LEVEL, 32'h000F0000);
		// Settling restarts on the level write; 50 cycles in this bench
		rdchk(`APC_ADDR_SETTLE, 32'h00000000);
		repeat (60) @(posedge clk_sys);
		rdchk(`APC_ADDR_SETTLE, 32'h00000001);
		host.wr_reg(`APC_ADDR_GAIN_BASE, 32'h00800001);
		rdchk(`APC_ADDR_GAIN_BASE, 32'h0F800001);
		rdchk(8'hFF, 32'h00000000);
		$display("register test done");
		foreach (rows[i]) begin
			rst();
			host.wr_reg(`APC_ADDR_MASK, 32'h40 << rows[i].ph);
			host.wr_reg(`APC_ADDR_ACC_MODE, 32'(rows[i].src) << 6);
			host.wr_reg((rows[i].offs ? `APC_ADDR_OFFS_BASE : `APC_ADDR_GAIN_BASE) + 8'(3 * rows[i].src + rows[i].ph),
				{8'h00, rows[i].cal});
			@(posedge clk_sys);
			tp[rows[i].ph] <= rows[i].src ? 28'h0000190 : 28'(rows[i].p);
			fp[rows[i].ph] <= rows[i].src ? 28'(rows[i].p) : 28'h0000190;
			n = 0;
			for (int k = 0; k < 20000 && irq_n !== 1'b0; k++) begin
				@(posedge clk_sys);
				#1;
				n += (sample_tick === 1'b1) ? 1 : 0;
			end
			chk(32'(n), 32'(ticks(rows[i])));
			rdchk(`APC_ADDR_STATUS, 32'h40 << rows[i].ph);
			rdchk(`APC_ADDR_SIGN, 32'h1 << rows[i].ph);
			host.wr_reg(`APC_ADDR_STATUS, 32'h00000000);
			repeat (2) @(negedge clk_sys);
			chk(32'(irq_n), 32'h00000000);
			host.wr_reg(`APC_ADDR_STATUS, 32'h000001C0);
			repeat (2) @(negedge clk_sys);
			chk(32'(irq_n), 32'h00000001);
			$display("row %0d done", i);
		end
		rst();
		@(posedge clk_sys);
		tp[0] <= 28'hFFFFC18;
		repeat (2600) @(posedge clk_sys);
		#1;
		chk(32'(irq_n), 32'h00000001);
		rdchk(`APC_ADDR_STATUS, 32'h00000040);
		host.wr_reg(`APC_ADDR_SIGN, 32'h00000000);
		rdchk(`APC_ADDR_SIGN, 32'h00000001);
		host.wr_reg(`APC_ADDR_MASK, 32'h00000040);
		repeat (2) @(negedge clk_sys);
		chk(32'(irq_n), 32'h00000000);
		rdchk(`APC_ADDR_MASK, 32'h00000040);
		rdchk(`APC_ADDR_THR_LO, 32'h000003E8);
		@(posedge clk_sys);
		tp[0] <= 28'h00003E8;
		repeat (2600) @(posedge clk_sys);
		rdchk(`APC_ADDR_SIGN, 32'h00000000);
		$display("masked test done");
		give_verdict();
	end
endmodule
